// ### dv/lmx_mem_model.sv
// lmx_mem_model.sv: data memory and control space behind lmx_exec.
// assumes one request at a time, answered within its own cycle.
`timescale 1ns/100ps
`default_nettype none
module lmx_mem_model (
  // clock and request
  input wire logic clk,
  input wire lmx_pkg::lmx_mem_req_t mem_req,
  // answer
  output logic [31:0] read_data
);
  logic [31:0] junk_q = 32'h5;
  // between requests the data lines wander so stale data is never mistaken for valid
  always @(posedge clk) junk_q <= junk_q + 32'h9E3779B9;
  // full word per address; the core keeps the half it needs
  assign read_data = mem_req.valid ? mem_req.addr ^ 32'hC3C35A5A : junk_q;
endmodule
`default_nettype wire

// ### dv/lmx_properties.sv
// lmx_properties.sv: port checks for lmx_exec, bound below.
// assumes memory data arrives in the same cycle as a request.
`timescale 1ns/100ps
`default_nettype none
module lmx_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // issue
  input wire logic ce,
  input wire logic issue_valid,
  input wire logic [31:0] syllable,
  input wire logic [31:0] first_source_value,
  input wire logic breakpoint_hit,
  input wire logic translation_miss,
  input wire logic in_control_space,
  input wire logic [31:0] read_data,
  // results
  input wire lmx_pkg::lmx_mem_req_t mem_req,
  input wire lmx_pkg::lmx_wb_t alu_wb,
  input wire lmx_pkg::lmx_wb_t load_wb,
  input wire lmx_pkg::lmx_fault_t fault
);
  logic ld, ok, ma, al, hw, bp, cs;
  logic [31:0] s, ea;
  logic [5:0] d, ldd;
  assign s = syllable;
  assign bp = breakpoint_hit;
  assign cs = in_control_space;
  assign ea = {{23{s[20]}}, s[20:12]} + first_source_value;
  assign hw = s[25];
  assign ld = ce && issue_valid && s[29:24] inside {6'h20, 6'h22};
  assign ma = hw ? ea[0] : |ea[1:0];
  assign ok = !bp && !translation_miss && !cs && !ma;
  assign al = ce && issue_valid && s[29:28] == 2'h0 && !s[26] && s[25:23] == 3'h4;
  assign d = s[27] ? s[11:6] : s[17:12];
  assign ldd = s[11:6];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_alu; al |=> alu_wb.valid && alu_wb.dest == $past(d); endproperty
  a_alu: assert property (p_alu) else $error("alu writeback late");
  property p_req; ld && ok |=> mem_req.valid && mem_req.addr == $past(ea); endproperty
  a_req: assert property (p_req) else $error("load request wrong");
  property p_lat; ld && ok |-> ##2 load_wb.valid && load_wb.dest == $past(ldd, 2); endproperty
  a_lat: assert property (p_lat) else $error("load writeback late");
  property p_bp; ld && bp |-> fault.data_breakpoint_fault ##1 !mem_req.valid; endproperty
  a_bp: assert property (p_bp) else $error("breakpoint missed");
  property p_cs; ld && hw && !s[23] && cs && !bp |-> fault.control_space_access_fault; endproperty
  a_cs: assert property (p_cs) else $error("control space fault missed");
  property p_dz;
    ld && s[23] && cs && !bp && !translation_miss |=> !mem_req.valid ##1 load_wb.data == 32'h0;
  endproperty
  a_dz: assert property (p_dz) else $error("dismissed load not zero");
  property p_hz;
    mem_req.valid && !mem_req.word |=> load_wb.data == ($past(read_data) & 32'h0000FFFF);
  endproperty
  a_hz: assert property (p_hz) else $error("half not zero extended");
  property p_al; ld && ma && !bp && !cs && !translation_miss |-> fault.alignment_fault; endproperty
  a_al: assert property (p_al) else $error("alignment fault missed");
  c_alu: cover property (al && s[27]);
  c_dz: cover property (ld && s[23] && cs);
  c_al: cover property (ld && ma);
endmodule
bind lmx_exec lmx_properties props (.*);
`default_nettype wire

// ### dv/testbench.sv
// testbench.sv: self-checking bench for lmx_exec with the memory model.
// assumes the checker binds itself to lmx_exec.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, issue_valid = 1'b0, illegal_op;
  logic breakpoint_hit = 1'b0, translation_miss = 1'b0, in_control_space = 1'b0;
  logic control_reg_unmapped = 1'b0, control_reg_denied = 1'b0;
  logic [31:0] syllable = 32'h0, first_source_value = 32'h0, second_source_value = 32'h0;
  logic [31:0] read_data;
  lmx_pkg::lmx_mem_req_t mem_req;
  lmx_pkg::lmx_wb_t alu_wb, load_wb;
  lmx_pkg::lmx_fault_t fault;
  int num_errors = 0, num_checks = 0, cycles = 0;
  lmx_exec dut (.*);
  lmx_mem_model mem (.*);
  always #25 clk = ~clk;
  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(string n, logic [38:0] e, logic [38:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_minmax();
    logic [38:0] pe;
    logic [31:0] a, b, bb;
    logic lt, gt;
    for (int i = 0; i < 17; i++) begin
      @(negedge clk);
      if (i > 0) chk("alu_wb", pe, alu_wb);
      issue_valid = i < 16;
      a = i[2] ? 32'h80000000 : 32'hFFFFFFFE;
      b = i[2] ? 32'h7FFFFFFF : 32'h3;
      bb = i[3] ? 32'hFFFFFFFF : b;
      lt = i[0] ? a < bb : $signed(a) < $signed(bb);
      gt = i[0] ? a > bb : $signed(a) > $signed(bb);
      pe = {i[3] ? 6'h7 : 6'h5, (i[1] ? lt : gt) ? a : bb, 1'b1};
      syllable = {4'h0, i[3], 4'h4, i[1:0], i[3] ? {9'h1FF, 6'h7} : {3'h0, 6'h5, 6'h2}, 6'h1};
      first_source_value = a;
      second_source_value = b;
    end
    $display("minmax done");
  endtask
  task automatic t_freeze();
    @(negedge clk);
    syllable = {4'h0, 1'b0, 4'h4, 2'h0, 3'h0, 6'h5, 6'h2, 6'h1};
    first_source_value = 32'h5;
    second_source_value = 32'h3;
    issue_valid = 1'b1;
    @(negedge clk);
    issue_valid = 1'b0;
    ce = 1'b0;
    chk("alu_wb", {6'h5, 32'h5, 1'b1}, alu_wb);
    @(negedge clk);
    chk("alu_wb_held", {6'h5, 32'h5, 1'b1}, alu_wb);
    ce = 1'b1;
    @(negedge clk);
    chk("alu_valid", 39'h0, {38'h0, alu_wb.valid});
    $display("freeze done");
  endtask
  // chk3 is {breakpoint, control space, translation miss}
  task automatic ld_case(logic [3:0] op, logic dis, logic [8:0] imm, logic [31:0] a,
    logic [2:0] chk3, logic [4:0] ef, logic go, logic wv);
    logic [31:0] ea, ed;
    logic [5:0] dst;
    ea = {{23{imm[8]}}, imm} + a;
    dst = op == 4'h0 ? 6'h3F : 6'hA;
    ed = ea ^ 32'hC3C35A5A;
    if (op != 4'h0) ed = ed & 32'hFFFF;
    if (!go) ed = 32'h0;
    @(negedge clk);
    syllable = {4'h2, op, dis, 2'h0, imm, dst, 6'h1};
    first_source_value = a;
    {breakpoint_hit, in_control_space, translation_miss} = chk3;
    issue_valid = 1'b1;
    #1 chk("fault", {34'h0, ef}, {34'h0, fault});
    @(negedge clk);
    issue_valid = 1'b0;
    {breakpoint_hit, in_control_space, translation_miss} = 3'h0;
    if (go) chk("mem_req", {4'h0, ea, op == 4'h0, dis, 1'b1}, {4'h0, mem_req});
    else chk("mem_valid", 39'h0, {38'h0, mem_req.valid});
    chk("illegal_op", 39'h0, {38'h0, illegal_op});
    @(negedge clk);
    chk("load_wb", wv ? {dst, ed, 1'b1} : 39'h0, wv ? load_wb : {38'h0, load_wb.valid});
    $display("load case done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_minmax();
    t_freeze();
    ld_case(4'h2, 1'b0, 9'h1FE, 32'h1004, 3'h0, 5'h0, 1'b1, 1'b1);
    ld_case(4'h2, 1'b0, 9'h4, 32'hFFFFFFFE, 3'h0, 5'h0, 1'b1, 1'b1);
    ld_case(4'h0, 1'b0, 9'h8, 32'h2000, 3'h0, 5'h0, 1'b1, 1'b1);
    ld_case(4'h0, 1'b1, 9'h8, 32'h2000, 3'h0, 5'h0, 1'b1, 1'b1);
    ld_case(4'h2, 1'b0, 9'h0, 32'h4000, 3'h6, 5'h10, 1'b0, 1'b0);
    ld_case(4'h2, 1'b0, 9'h0, 32'h4000, 3'h2, 5'h8, 1'b0, 1'b0);
    ld_case(4'h2, 1'b1, 9'h0, 32'h4000, 3'h2, 5'h0, 1'b0, 1'b1);
    ld_case(4'h0, 1'b1, 9'h0, 32'h4000, 3'h2, 5'h0, 1'b0, 1'b1);
    ld_case(4'h2, 1'b0, 9'h1, 32'h4000, 3'h0, 5'h1, 1'b0, 1'b0);
    ld_case(4'h0, 1'b0, 9'h2, 32'h4000, 3'h0, 5'h1, 1'b0, 1'b0);
    @(negedge clk);
    complete_run();
  end
endmodule
`default_nettype wire

// ### hdl/lmx_exec.sv
// lmx_exec.sv: decodes and executes unsigned half-word and word loads and min/max.
// assumes one syllable per cycle, memory answers in the same cycle as a request,
// and the issue logic keeps bundle and link register restrictions.
`timescale 1ns/100ps
`default_nettype none
`include "lmx_regs.svh"
module lmx_exec (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // issue side
  input wire logic issue_valid,
  input wire logic [31:0] syllable,
  input wire logic [31:0] first_source_value,
  input wire logic [31:0] second_source_value,
  // checks from translation, breakpoint and control space
  input wire logic breakpoint_hit,
  input wire logic translation_miss,
  input wire logic in_control_space,
  input wire logic control_reg_unmapped,
  input wire logic control_reg_denied,
  // memory and control register answer
  input wire logic [31:0] read_data,
  // outputs
  output lmx_pkg::lmx_mem_req_t mem_req,
  output lmx_pkg::lmx_wb_t alu_wb,
  output lmx_pkg::lmx_wb_t load_wb,
  output lmx_pkg::lmx_fault_t fault,
  output logic illegal_op
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] sext9(input logic [8:0] v);
    sext9 = {{23{v[8]}}, v};
  endfunction
  function automatic logic less(input logic [31:0] a, input logic [31:0] b,
                                input logic sgn);
    less = sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic [1:0] cls;
  logic [3:0] ldop;
  logic [4:0] aluop;
  logic is_ldhu, is_ldw, is_load, is_mm, dism, immf;
  logic [31:0] imm, ea, opb, mm_res;
  logic [5:0] ld_dest, mm_dest;
  logic misal, ld_fault, gt, lt;
  assign cls = syllable[`LMX_CLASS_HI:`LMX_CLASS_LO];
  assign ldop = syllable[`LMX_LDOP_HI:`LMX_LDOP_LO];
  assign aluop = syllable[`LMX_ALUOP_HI:`LMX_ALUOP_LO];
  assign dism = syllable[`LMX_DISMISS_BIT];
  assign immf = syllable[`LMX_IMMFORM_BIT];
  assign imm = sext9(syllable[`LMX_IMM_HI:`LMX_IMM_LO]);
  assign is_ldhu = issue_valid && cls == `LMX_CLASS_LDST && ldop == `LMX_OP_LDHU;
  assign is_ldw = issue_valid && cls == `LMX_CLASS_LDST && ldop == `LMX_OP_LDW;
  assign is_load = is_ldhu || is_ldw;
  assign is_mm = issue_valid && cls == `LMX_CLASS_ALU && !syllable[`LMX_BIT26]
                 && (aluop == `LMX_OP_MAX || aluop == `LMX_OP_MAXU
                 || aluop == `LMX_OP_MIN || aluop == `LMX_OP_MINU);
  // any general register is a legal word load destination
  assign ld_dest = syllable[`LMX_IDEST_HI:`LMX_IDEST_LO];
  assign mm_dest = immf ? syllable[`LMX_IDEST_HI:`LMX_IDEST_LO]
                        : syllable[`LMX_DEST_HI:`LMX_DEST_LO];
  ////////////////////////////////////////////////////////////////////////////
  // address and checks
  assign ea = imm + first_source_value;
  assign misal = is_ldhu ? |(ea & `LMX_HALF_ALIGN) : |(ea & `LMX_WORD_ALIGN);
  // breakpoint is checked first and masks later faults; dismissable
  // loads in control space raise nothing else
  always_comb begin
    fault = '0;
    if (is_load) begin
      if (breakpoint_hit) begin
        fault.data_breakpoint_fault = 1'b1;
      end else if (in_control_space && !dism) begin
        if (is_ldhu) begin
          fault.control_space_access_fault = 1'b1;
        end else begin
          fault.control_space_access_fault = control_reg_denied;
          fault.control_space_unmapped_fault = control_reg_unmapped && !control_reg_denied;
        end
      end else if (!in_control_space) begin
        fault.data_translation_fault = translation_miss;
        fault.alignment_fault = misal && !translation_miss;
      end
    end
  end
  assign ld_fault = |fault;
  ////////////////////////////////////////////////////////////////////////////
  // min/max
  assign opb = immf ? imm : second_source_value;
  assign gt = less(opb, first_source_value, aluop == `LMX_OP_MAX);
  assign lt = less(first_source_value, opb, aluop == `LMX_OP_MIN);
  always_comb begin
    case (aluop)
      `LMX_OP_MAX, `LMX_OP_MAXU: mm_res = gt ? first_source_value : opb;
      `LMX_OP_MIN, `LMX_OP_MINU: mm_res = lt ? first_source_value : opb;
      default: mm_res = opb;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // registered outputs: min/max result one cycle after issue
  logic illegal_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alu_wb <= '0;
    end else if (ce) begin
      alu_wb.valid <= is_mm;
      alu_wb.dest <= mm_dest;
      alu_wb.data <= mm_res;
    end
  end
  // control space dismissable loads issue no memory request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_req <= '0;
    end else if (ce) begin
      mem_req.valid <= is_load && !ld_fault && !(dism && in_control_space);
      mem_req.addr <= ea;
      mem_req.word <= is_ldw;
      mem_req.dismiss <= dism;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      illegal_q <= 1'b0;
    end else if (ce) begin
      // half-word loads must not target the return target register
      illegal_q <= is_ldhu && ld_dest == `LMX_RET_REG;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // load pipeline: issue stage then return stage, result two cycles after issue
  lmx_pkg::lmx_state_t st_q;
  logic [5:0] p_dest_q;
  logic p_half_q, p_zero_q;
  logic [31:0] ld_data;
  logic [37:0] stage_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= lmx_pkg::LMX_IDLE;
      p_dest_q <= 6'h0;
      p_half_q <= 1'b0;
      p_zero_q <= 1'b0;
    end else if (ce) begin
      case (st_q)
        lmx_pkg::LMX_IDLE, lmx_pkg::LMX_WAIT: begin
          st_q <= (is_load && !ld_fault) ? lmx_pkg::LMX_WAIT : lmx_pkg::LMX_IDLE;
          p_dest_q <= ld_dest;
          p_half_q <= is_ldhu;
          p_zero_q <= dism && in_control_space;
        end
        default: st_q <= lmx_pkg::LMX_IDLE;
      endcase
    end
  end
  always_comb begin
    if (p_zero_q) begin
      ld_data = `LMX_ZERO_WORD;
    end else if (p_half_q) begin
      ld_data = read_data & `LMX_HALF_MASK;
    end else begin
      ld_data = read_data;
    end
  end
  lmx_stage u_ret (
    .clk(clk),
    .rst_b(rst_b),
    .en(ce),
    .d({p_dest_q, ld_data}),
    .q(stage_q)
  );
  logic ld_valid_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_valid_q <= 1'b0;
    end else if (ce) begin
      ld_valid_q <= st_q == lmx_pkg::LMX_WAIT;
    end
  end
  assign load_wb.valid = ld_valid_q;
  assign load_wb.dest = stage_q[37:32];
  assign load_wb.data = stage_q[31:0];
  assign illegal_op = illegal_q;
endmodule
`default_nettype wire

// ### hdl/lmx_stage.sv
// lmx_stage.sv: 38-bit pipeline register (destination and data word) with enable, used for the load return stage.
// assumes the caller gates en with its clock enable.
`timescale 1ns/100ps
`default_nettype none
module lmx_stage (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // data
  input wire logic en,
  input wire logic [37:0] d,
  output logic [37:0] q
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= 38'h0;
    end else if (en) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ### include/lmx_pkg.sv
// lmx_pkg.sv: carrier types for the load and min/max slice.
// assumes lmx_regs.svh supplies the numbers.
package lmx_pkg;
  typedef enum logic [1:0] {
    LMX_IDLE = 2'b00,
    LMX_WAIT = 2'b01
  } lmx_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic        word;
    logic        dismiss;
    logic        valid;
  } lmx_mem_req_t;
  typedef struct packed {
    logic [5:0]  dest;
    logic [31:0] data;
    logic        valid;
  } lmx_wb_t;
  typedef struct packed {
    logic data_breakpoint_fault;
    logic control_space_access_fault;
    logic control_space_unmapped_fault;
    logic data_translation_fault;
    logic alignment_fault;
  } lmx_fault_t;
endpackage

// ### include/lmx_regs.svh
// lmx_regs.svh: encodings, field positions and fixed values for the load and min/max slice.
// assumes a 32-bit syllable and a 64-entry general register file.
`ifndef LMX_REGS_SVH
`define LMX_REGS_SVH
`define LMX_CLASS_HI 29
`define LMX_CLASS_LO 28
`define LMX_CLASS_LDST 2'h2
`define LMX_CLASS_ALU 2'h0
`define LMX_LDOP_HI 27
`define LMX_LDOP_LO 24
`define LMX_OP_LDHU 4'h2
`define LMX_OP_LDW 4'h0
`define LMX_DISMISS_BIT 23
`define LMX_IMMFORM_BIT 27
`define LMX_BIT26 26
`define LMX_ALUOP_HI 25
`define LMX_ALUOP_LO 21
`define LMX_OP_MAX 5'h10
`define LMX_OP_MAXU 5'h11
`define LMX_OP_MIN 5'h12
`define LMX_OP_MINU 5'h13
`define LMX_IMM_HI 20
`define LMX_IMM_LO 12
`define LMX_IDEST_HI 11
`define LMX_IDEST_LO 6
`define LMX_DEST_HI 17
`define LMX_DEST_LO 12
`define LMX_SECOND_SOURCE_FIELD_HI 11
`define LMX_SECOND_SOURCE_FIELD_LO 6
`define LMX_FIRST_SOURCE_FIELD_HI 5
`define LMX_FIRST_SOURCE_FIELD_LO 0
`define LMX_RET_REG 6'h3F
`define LMX_HALF_MASK 32'h0000FFFF
`define LMX_ZERO_WORD 32'h00000000
`define LMX_HALF_ALIGN 32'h00000001
`define LMX_WORD_ALIGN 32'h00000003
`endif
